// File: design/squib_driver_command_decoder.v
// command decoder behind the byte spi slave of a four channel squib driver
`timescale 1ns/1ps
`include "squib_cmd_regs.vh"
module squib_driver_command_decoder #(
  parameter CHANNELS = 4
) (
  input wire clk,
  input wire sys_rst,
  input wire spiClk,
  input wire spiCsN,
  input wire spiMosi,
  output wire spiMiso,
  output wire spiMisoOeN,
  input wire firing_enable_input_one,
  input wire firing_enable_input_two,
  input wire firingActive,
  input wire [CHANNELS-1:0] high_transistor_test_level,
  input wire [CHANNELS-1:0] low_transistor_test_level,
  input wire [3:0] fenStatusUpper,
  output reg [7:0] firing_enable_one_count,
  output reg [7:0] firing_enable_two_count,
  output reg [CHANNELS-1:0] measResetPulse,
  output reg [CHANNELS-1:0] highDriverOn,
  output reg [CHANNELS-1:0] lowDriverOn
);
  localparam ARM_NONE = 3'h0;
  localparam ARM_COUNT_ONE = 3'h1;
  localparam ARM_COUNT_TWO = 3'h2;
  localparam ARM_HIGH = 3'h3;
  localparam ARM_LOW = 3'h4;

  reg [2:0] armState;
  reg [2:0] next_armState;
  reg [7:0] response;
  reg [7:0] next_response;
  reg [1:0] fenSyncA;
  reg [1:0] fenSyncB;
  reg [1:0] fireSync;
  reg [3:0] upperSync0;
  reg [3:0] upperSync1;
  reg [CHANNELS-1:0] highSync0;
  reg [CHANNELS-1:0] highSync1;
  reg [CHANNELS-1:0] lowSync0;
  reg [CHANNELS-1:0] lowSync1;
  reg [CHANNELS-1:0] high_driver_test_result;
  reg [CHANNELS-1:0] low_driver_test_result;
  reg highPending;
  reg lowPending;
  wire [7:0] rxByte;
  wire rxDone;
  wire [3:0] rxNibble;
  wire secondOk;

  // response register feeds the slave, so each answer leaves one frame later
  spi_byte_slave spiPort (
    .clk(clk),
    .sys_rst(sys_rst),
    .spiClk(spiClk),
    .spiCsN(spiCsN),
    .spiMosi(spiMosi),
    .spiMiso(spiMiso),
    .spiMisoOeN(spiMisoOeN),
    .txByte(response),
    .rxByte(rxByte),
    .rxDone(rxDone)
  );

  // analog levels and enable pins are asynchronous to clk
  always @(posedge clk) begin
    if (sys_rst) begin
      fenSyncA <= 2'h0;
      fenSyncB <= 2'h0;
      fireSync <= 2'h0;
      upperSync0 <= 4'h0;
      upperSync1 <= 4'h0;
      highSync0 <= {CHANNELS{1'b0}};
      highSync1 <= {CHANNELS{1'b0}};
      lowSync0 <= {CHANNELS{1'b0}};
      lowSync1 <= {CHANNELS{1'b0}};
    end else begin
      fenSyncA <= {fenSyncA[0], firing_enable_input_one};
      fenSyncB <= {fenSyncB[0], firing_enable_input_two};
      fireSync <= {fireSync[0], firingActive};
      upperSync0 <= fenStatusUpper;
      upperSync1 <= upperSync0;
      highSync0 <= high_transistor_test_level;
      highSync1 <= highSync0;
      lowSync0 <= low_transistor_test_level;
      lowSync1 <= lowSync0;
    end
  end

  assign rxNibble = rxByte[7:4];
  // guard that blocks every armed second byte while firingActive is synchronised high
  assign secondOk = ~fireSync[1];

  // decode one received byte into next arm state and next response
  always @* begin
    next_armState = ARM_NONE;
    next_response = `RESERVED_RESPONSE;
    if (armState != ARM_NONE && secondOk && armState == ARM_COUNT_ONE) begin
      next_response = rxByte;
    end else if (armState != ARM_NONE && secondOk && armState == ARM_COUNT_TWO) begin
      next_response = rxByte;
    end else if (armState == ARM_HIGH && secondOk && rxNibble == `CMD_NIBBLE_HIGH_TEST) begin
      next_response = 8'h00;
    end else if (armState == ARM_LOW && secondOk && rxNibble == `CMD_NIBBLE_LOW_TEST) begin
      next_response = 8'h00;
    end else if (rxNibble == `CMD_NIBBLE_MEAS_RESET) begin
      next_response = rxByte;
    end else begin
      case (rxByte)
        `CMD_UNLOCK_COUNT_ONE: begin
          next_armState = ARM_COUNT_ONE;
          next_response = rxByte;
        end
        `CMD_UNLOCK_COUNT_TWO: begin
          next_armState = ARM_COUNT_TWO;
          next_response = rxByte;
        end
        `CMD_UNLOCK_HIGH_TEST: begin
          next_armState = ARM_HIGH;
          next_response = rxByte;
        end
        `CMD_UNLOCK_LOW_TEST: begin
          next_armState = ARM_LOW;
          next_response = rxByte;
        end
        `CMD_INTEGRITY: begin
          next_response = `RESP_INTEGRITY;
        end
        `CMD_FEN_STATUS: begin
          next_response = {upperSync1, 2'b00, fenSyncB[1], fenSyncA[1]};
        end
        default: begin
          // reserved and unknown codes answer zero
          next_response = `RESERVED_RESPONSE;
        end
      endcase
    end
  end

  // frame-level state; test results captured one cycle after drivers turn on
  always @(posedge clk) begin
    if (sys_rst) begin
      armState <= ARM_NONE;
      response <= `RESET_RESPONSE;
      firing_enable_one_count <= `RESET_COUNT_VALUE;
      firing_enable_two_count <= `RESET_COUNT_VALUE;
      measResetPulse <= {CHANNELS{1'b0}};
      highDriverOn <= {CHANNELS{1'b0}};
      lowDriverOn <= {CHANNELS{1'b0}};
      high_driver_test_result <= {CHANNELS{1'b0}};
      low_driver_test_result <= {CHANNELS{1'b0}};
      highPending <= 1'b0;
      lowPending <= 1'b0;
    end else begin
      measResetPulse <= {CHANNELS{1'b0}};
      highPending <= 1'b0;
      lowPending <= 1'b0;
      if (highPending) begin
        high_driver_test_result <= highSync1;
        response <= {4'h0, highSync1};
      end
      if (lowPending) begin
        low_driver_test_result <= lowSync1;
        response <= {4'h0, lowSync1};
      end
      if (rxDone) begin
        armState <= next_armState;
        response <= next_response;
        // test drivers stay on only until the next command frame
        highDriverOn <= {CHANNELS{1'b0}};
        lowDriverOn <= {CHANNELS{1'b0}};
        if (armState == ARM_COUNT_ONE && secondOk) begin
          firing_enable_one_count <= rxByte;
        end else if (armState == ARM_COUNT_TWO && secondOk) begin
          firing_enable_two_count <= rxByte;
        end else if (armState == ARM_HIGH && secondOk && rxNibble == `CMD_NIBBLE_HIGH_TEST) begin
          highDriverOn <= rxByte[CHANNELS-1:0];
          highPending <= 1'b1;
        end else if (armState == ARM_LOW && secondOk && rxNibble == `CMD_NIBBLE_LOW_TEST) begin
          lowDriverOn <= rxByte[CHANNELS-1:0];
          lowPending <= 1'b1;
        end else if (rxNibble == `CMD_NIBBLE_MEAS_RESET) begin
          measResetPulse <= rxByte[CHANNELS-1:0];
        end
      end
    end
  end
endmodule // squib_driver_command_decoder

// File: design/squib_cmd_regs.vh
// constants for the squib driver command decoder
`ifndef SQUIB_CMD_REGS_VH
`define SQUIB_CMD_REGS_VH
`define CMD_NIBBLE_HIGH_TEST 4'h1
`define CMD_NIBBLE_LOW_TEST 4'h2
`define CMD_NIBBLE_MEAS_RESET 4'h3
`define CMD_UNLOCK_COUNT_ONE 8'h80
`define CMD_UNLOCK_COUNT_TWO 8'h81
`define CMD_UNLOCK_HIGH_TEST 8'h82
`define CMD_UNLOCK_LOW_TEST 8'h83
`define CMD_RESERVED_FIRST 8'h90
`define CMD_RESERVED_LAST 8'h93
`define CMD_INTEGRITY 8'h96
`define RESP_INTEGRITY 8'h69
`define CMD_FEN_STATUS 8'hC8
`define RESET_COUNT_VALUE 8'h00
`define RESET_RESPONSE 8'h00
`define RESERVED_RESPONSE 8'h00
`define FRAME_BITS 8
`endif

// File: design/spi_byte_slave.v
// 8-bit spi slave, mode 0, msb first, with synchronised pins
`timescale 1ns/1ps
`include "squib_cmd_regs.vh"
module spi_byte_slave (
  input wire clk,
  input wire sys_rst,
  input wire spiClk,
  input wire spiCsN,
  input wire spiMosi,
  output reg spiMiso,
  output wire spiMisoOeN,
  input wire [7:0] txByte,
  output reg [7:0] rxByte,
  output reg rxDone
);
  reg [2:0] sckSync;
  reg [1:0] csSync;
  reg [1:0] mosiSync;
  reg [7:0] shiftReg;
  reg [3:0] bitCount;
  wire sckRise;
  wire sckFall;
  wire csActive;
  wire csStart;
  reg csPrev;

  // two-flop synchronisers; edges taken between second and third stage
  always @(posedge clk) begin
    if (sys_rst) begin
      sckSync <= 3'h0;
      csSync <= 2'h3;
      mosiSync <= 2'h0;
      csPrev <= 1'b0;
    end else begin
      sckSync <= {sckSync[1:0], spiClk};
      csSync <= {csSync[0], spiCsN};
      mosiSync <= {mosiSync[0], spiMosi};
      csPrev <= csActive;
    end
  end

  assign sckRise = sckSync[1] & ~sckSync[2];
  assign sckFall = ~sckSync[1] & sckSync[2];
  assign csActive = ~csSync[1];
  assign csStart = csActive & ~csPrev;
  // miso released whenever chip select is high
  assign spiMisoOeN = ~csActive;

  // shift in on rising, out on falling; response loaded at frame start
  always @(posedge clk) begin
    if (sys_rst) begin
      shiftReg <= 8'h00;
      bitCount <= 4'h0;
      spiMiso <= 1'b0;
      rxByte <= 8'h00;
      rxDone <= 1'b0;
    end else begin
      rxDone <= 1'b0;
      if (csStart) begin
        shiftReg <= txByte;
        spiMiso <= txByte[7];
        bitCount <= 4'h0;
      end else if (csActive) begin
        if (sckRise && bitCount < `FRAME_BITS) begin
          shiftReg <= {shiftReg[6:0], mosiSync[1]};
          bitCount <= bitCount + 4'h1;
        end else if (sckFall && bitCount < `FRAME_BITS) begin
          spiMiso <= shiftReg[7];
        end
      end else if (csPrev) begin
        // short frames are dropped; a long frame keeps only its first eight bits
        if (bitCount == `FRAME_BITS) begin
          rxByte <= shiftReg;
          rxDone <= 1'b1;
        end
      end
    end
  end
endmodule // spi_byte_slave

// File: tb/squib_host_model.sv
// host spi master model, mode 0, one byte per start request
`timescale 1ns/1ps
module squib_host_model (
  input wire clk,
  input wire start,
  input wire [7:0] txData,
  input wire spiMiso,
  output reg spiClk,
  output reg spiCsN,
  output reg spiMosi,
  output reg [7:0] rxData,
  output reg done
);
  integer i;
  // one full eight bit frame; half periods of 4 clk, 6 clk gap after cs rises
  initial begin
    spiClk = 0;
    spiCsN = 1;
    spiMosi = 0;
    rxData = 0;
    done = 0;
    forever begin
      @(negedge clk);
      if (start) begin
        spiCsN = 0;
        for (i = 7; i >= 0; i = i - 1) begin
          spiMosi = txData[i];
          repeat (4) @(negedge clk);
          spiClk = 1;
          rxData = {rxData[6:0], spiMiso};
          repeat (4) @(negedge clk);
          spiClk = 0;
        end
        // released line shows the inverse so a stale bit is never trusted
        spiMosi = ~spiMosi;
        repeat (4) @(negedge clk);
        spiCsN = 1;
        repeat (6) @(negedge clk);
        done = 1;
        @(negedge clk);
        done = 0;
      end
    end
  end
endmodule // squib_host_model

// File: tb/squib_driver_command_decoder_props.sv
// assertions on the ports of the command decoder
`timescale 1ns/1ps
module squib_driver_command_decoder_props #(
  parameter CHANNELS = 4
) (
  input wire clk,
  input wire sys_rst,
  input wire spiCsN,
  input wire spiMisoOeN,
  input wire firingActive,
  input wire [7:0] firing_enable_one_count,
  input wire [7:0] firing_enable_two_count,
  input wire [CHANNELS-1:0] measResetPulse,
  input wire [CHANNELS-1:0] highDriverOn,
  input wire [CHANNELS-1:0] lowDriverOn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_cs_idle; spiCsN [*4]; endsequence
  sequence s_cs_busy; !spiCsN [*4]; endsequence
  sequence s_fire_held; firingActive [*8]; endsequence
  property p_oe_idle; s_cs_idle |-> spiMisoOeN; endproperty
  property p_oe_busy; s_cs_busy |-> !spiMisoOeN; endproperty
  property p_rst; $fell(sys_rst) |-> firing_enable_one_count == 8'h00
    && firing_enable_two_count == 8'h00 && highDriverOn == 0 && lowDriverOn == 0; endproperty
  property p_pulse; |measResetPulse |=> measResetPulse == 0; endproperty
  property p_cnt_cs; $changed(firing_enable_one_count) || $changed(firing_enable_two_count)
    |-> spiCsN; endproperty
  property p_drv_cs; $changed(highDriverOn) || $changed(lowDriverOn) |-> spiCsN; endproperty
  property p_fire_one; s_fire_held |=> $stable(firing_enable_one_count); endproperty
  property p_fire_two; s_fire_held |=> $stable(firing_enable_two_count); endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("miso driven while idle");
  a_oe_busy: assert property (p_oe_busy) else $error("miso not driven in frame");
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  a_cnt_cs: assert property (p_cnt_cs) else $error("count changed inside frame");
  a_drv_cs: assert property (p_drv_cs) else $error("driver changed inside frame");
  a_fire_one: assert property (p_fire_one) else $error("count one loaded while firing");
  a_fire_two: assert property (p_fire_two) else $error("count two loaded while firing");
endmodule // squib_driver_command_decoder_props
bind squib_driver_command_decoder squib_driver_command_decoder_props #(.CHANNELS(CHANNELS))
  u_props (.clk(clk), .sys_rst(sys_rst), .spiCsN(spiCsN), .spiMisoOeN(spiMisoOeN),
  .firingActive(firingActive), .firing_enable_one_count(firing_enable_one_count),
  .firing_enable_two_count(firing_enable_two_count), .measResetPulse(measResetPulse),
  .highDriverOn(highDriverOn), .lowDriverOn(lowDriverOn));

// File: tb/squib_driver_command_decoder_test.sv
// self-checking bench for the squib driver command decoder
`timescale 1ns/1ps
module squib_driver_command_decoder_test;
  reg clk, sys_rst, start, fen1, fen2, fire;
  reg [7:0] txData, v1, v2;
  reg [3:0] hiLvl, loLvl, upper, n1, n2, n3, seenPulse;
  wire spiClk, spiCsN, spiMosi, spiMiso, spiMisoOeN, done;
  wire [7:0] rxData, cnt1, cnt2;
  wire [3:0] pulse, hiOn, loOn;
  reg [7:0] expQ[$];
  integer fails = 0;
  integer cmp_count = 0;
  // free running 200 MHz clock
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  squib_host_model u_host (.clk(clk), .start(start), .txData(txData), .spiMiso(spiMiso),
    .spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi), .rxData(rxData), .done(done));
  squib_driver_command_decoder u_dut (.clk(clk), .sys_rst(sys_rst), .spiClk(spiClk),
    .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOeN(spiMisoOeN),
    .firing_enable_input_one(fen1), .firing_enable_input_two(fen2), .firingActive(fire),
    .high_transistor_test_level(hiLvl), .low_transistor_test_level(loLvl),
    .fenStatusUpper(upper), .firing_enable_one_count(cnt1), .firing_enable_two_count(cnt2),
    .measResetPulse(pulse), .highDriverOn(hiOn), .lowDriverOn(loOn));
  task cmp8(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // one frame; the note holds the answer to the previous command
  task xfer(input [7:0] cmd, input [7:0] exp);
    integer n;
    begin
      expQ.push_back(exp);
      @(negedge clk);
      txData <= cmd;
      start <= 1;
      @(negedge clk);
      start <= 0;
      n = 0;
      while (done !== 1'b1 && n < 300) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n >= 300) begin
        fails = fails + 1;
        give_verdict;
      end
    end
  endtask
  // watcher pairs each received byte with the oldest note
  always @(posedge clk) begin
    if (done === 1'b1) cmp8(rxData, expQ.pop_front());
    if (pulse !== 4'h0) seenPulse <= pulse;
  end
  initial begin
    sys_rst = 1; start = 0; txData = 0; fire = 0; seenPulse = 0;
    void'($urandom(32'h3893));
    {hiLvl, loLvl, upper, n1, n2, n3} = $urandom;
    {fen1, fen2, v1, v2} = $urandom;
    repeat (2) @(posedge clk);
    @(negedge clk) sys_rst = 0;
    repeat (4) @(negedge clk);
    cmp8(cnt1, 8'h00);
    cmp8(cnt2, 8'h00);
    xfer(8'h80, 8'h00);
    xfer(v1, 8'h80);
    cmp8(cnt1, v1);
    xfer(8'h81, v1);
    xfer(v2, 8'h81);
    cmp8(cnt2, v2);
    xfer(8'h82, v2);
    xfer({4'h1, n1}, 8'h82);
    cmp8(hiOn, n1);
    xfer(8'h83, {4'h0, hiLvl});
    xfer({4'h2, n2}, 8'h83);
    cmp8(loOn, n2);
    xfer({4'h3, n3}, {4'h0, loLvl});
    cmp8(seenPulse, n3);
    xfer(8'h96, {4'h3, n3});
    xfer(8'hC8, 8'h69);
    xfer(8'h80, {upper, 2'b00, fen2, fen1});
    // the frame right after a count unlock is its data byte, whatever its value, while firingActive is low
    xfer(8'h96, 8'h80);
    xfer(8'h55, 8'h96);
    cmp8(cnt1, 8'h96);
    fire <= 1'b1;
    // with firingActive high the armed data byte is refused, so count two keeps v2
    xfer(8'h81, 8'h00);
    xfer(8'hA5, 8'h81);
    cmp8(cnt2, v2);
    fire <= 1'b0;
    xfer(8'h00, 8'h00);
    give_verdict;
  end
endmodule // squib_driver_command_decoder_test
